// ==== sgm_defs.svh ====
// register offsets, field positions, widths and reset values of the signal modulator
`ifndef SGM_DEFS_SVH
`define SGM_DEFS_SVH

`define SGM_ADDR_W 8
`define SGM_DATA_W 32

`define SGM_OFS_CTRL0 8'h00
`define SGM_OFS_CTRL1 8'h04
`define SGM_OFS_MODSRC 8'h08
`define SGM_OFS_CARRIER_HIGH 8'h0C
`define SGM_OFS_CARRIER_LOW 8'h10

`define SGM_CTRL0_EN 7
`define SGM_CTRL0_OUT 5
`define SGM_CTRL0_OINV 4
`define SGM_CTRL0_BIT 0

`define SGM_CTRL1_CHINV 5
`define SGM_CTRL1_HIGH_CARRIER_SYNC_EN 4
`define SGM_CTRL1_CLINV 1
`define SGM_CTRL1_LOW_CARRIER_SYNC_EN 0

`define SGM_MS_W 5
`define SGM_CAR_W 4
`define SGM_MOD_SRCS 32
`define SGM_CAR_SRCS 16

`define SGM_MS_SOFT_BIT 5'h00
`define SGM_RST_MS 5'h00
`define SGM_RST_CAR 4'h0

`endif

// ==== sgm_pkg.sv ====
// types shared by the signal modulator
`default_nettype none

package sgm_pkg;

   typedef enum logic {
      SGM_CAR_LOW,
      SGM_CAR_HIGH
   } sgm_car_t;

endpackage : sgm_pkg

`default_nettype wire

// ==== sgm_sync.sv ====
// two-flop level synchroniser for a bank of input levels
`timescale 1ns/1ns
`default_nettype none

module sgm_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_q;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         meta_q <= '0;
         q_o <= '0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end

endmodule : sgm_sync

`default_nettype wire

// ==== sgm_pick.sv ====
// source selector: picks one level out of a bank by index
`timescale 1ns/1ns
`default_nettype none

module sgm_pick #(
   parameter int N = 16,
   parameter int SW = 4
) (
   input wire logic [N-1:0] src_i,
   input wire logic [SW-1:0] sel_i,
   output logic pick_o
);

   always_comb begin
      pick_o = src_i[sel_i];
   end

endmodule : sgm_pick

`default_nettype wire

// ==== sgm_modulator.sv ====
// signal modulator: apb registers, source selection, carrier switching and output mixing
`timescale 1ns/1ns
`default_nettype none
`include "sgm_defs.svh"

module sgm_modulator (
   input wire logic CLOCK_I,
   input wire logic SRST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [`SGM_ADDR_W-1:0] PADDR_I,
   input wire logic [`SGM_DATA_W-1:0] PWDATA_I,
   output logic [`SGM_DATA_W-1:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic [`SGM_MOD_SRCS-1:0] MOD_SRC_I,
   input wire logic [`SGM_CAR_SRCS-1:0] CARRIER_HIGH_SRC_I,
   input wire logic [`SGM_CAR_SRCS-1:0] CARRIER_LOW_SRC_I,
   output logic MODULATED_OUTPUT_PIN_O
);

   // register state
   logic en_q;
   logic out_inv_q;
   logic soft_bit_q;
   logic high_carrier_invert_q;
   logic high_carrier_sync_en_q;
   logic low_carrier_invert_q;
   logic low_carrier_sync_en_q;
   logic [`SGM_MS_W-1:0] mod_source_sel_q;
   logic [`SGM_CAR_W-1:0] high_carrier_sel_q;
   logic [`SGM_CAR_W-1:0] low_carrier_sel_q;

   // bus handshake
   logic access;
   logic wr_take;
   logic hit;
   logic [`SGM_DATA_W-1:0] rd_word;

   // datapath
   logic [`SGM_MOD_SRCS-1:0] mod_sync;
   logic [`SGM_CAR_SRCS-1:0] carrier_high_sync;
   logic [`SGM_CAR_SRCS-1:0] carrier_low_sync;
   logic mod_pick;
   logic carrier_high_pick;
   logic carrier_low_pick;
   logic modulator_signal;
   logic carrier_high;
   logic carrier_low;
   logic mix;
   logic out_q;
   sgm_pkg::sgm_car_t car_q;
   sgm_pkg::sgm_car_t car_d;

   function automatic logic addr_mapped(input logic [`SGM_ADDR_W-1:0] a);
      addr_mapped = (a == `SGM_OFS_CTRL0) || (a == `SGM_OFS_CTRL1) ||
                    (a == `SGM_OFS_MODSRC) || (a == `SGM_OFS_CARRIER_HIGH) ||
                    (a == `SGM_OFS_CARRIER_LOW);
   endfunction : addr_mapped

   // ---------------------------------------------------------------- apb slave
   // one wait state: ready rises in the second access cycle
   assign access = PSEL_I && PENABLE_I;
   assign wr_take = access && PREADY_O && PWRITE_I && hit;
   assign hit = addr_mapped(PADDR_I);

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
      end else begin
         PREADY_O <= access && !PREADY_O;
         PSLVERR_O <= access && !PREADY_O && !hit;
      end
   end

   always_comb begin
      rd_word = '0;
      case (PADDR_I)
         `SGM_OFS_CTRL0: begin
            rd_word[`SGM_CTRL0_EN] = en_q;
            rd_word[`SGM_CTRL0_OUT] = out_q;
            rd_word[`SGM_CTRL0_OINV] = out_inv_q;
            rd_word[`SGM_CTRL0_BIT] = soft_bit_q;
         end
         `SGM_OFS_CTRL1: begin
            rd_word[`SGM_CTRL1_CHINV] = high_carrier_invert_q;
            rd_word[`SGM_CTRL1_HIGH_CARRIER_SYNC_EN] = high_carrier_sync_en_q;
            rd_word[`SGM_CTRL1_CLINV] = low_carrier_invert_q;
            rd_word[`SGM_CTRL1_LOW_CARRIER_SYNC_EN] = low_carrier_sync_en_q;
         end
         `SGM_OFS_MODSRC: begin
            rd_word[`SGM_MS_W-1:0] = mod_source_sel_q;
         end
         `SGM_OFS_CARRIER_HIGH: begin
            rd_word[`SGM_CAR_W-1:0] = high_carrier_sel_q;
         end
         `SGM_OFS_CARRIER_LOW: begin
            rd_word[`SGM_CAR_W-1:0] = low_carrier_sel_q;
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         PRDATA_O <= '0;
      end else if (access && !PREADY_O && !PWRITE_I) begin
         PRDATA_O <= rd_word;
      end
   end

   // ------------------------------------------------------------ control regs
   // enable, output invert and soft bit
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         en_q <= 1'b0;
         out_inv_q <= 1'b0;
         soft_bit_q <= 1'b0;
      end else if (wr_take && PADDR_I == `SGM_OFS_CTRL0) begin
         en_q <= PWDATA_I[`SGM_CTRL0_EN];
         out_inv_q <= PWDATA_I[`SGM_CTRL0_OINV];
         soft_bit_q <= PWDATA_I[`SGM_CTRL0_BIT];
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         high_carrier_invert_q <= 1'b0;
         high_carrier_sync_en_q <= 1'b0;
         low_carrier_invert_q <= 1'b0;
         low_carrier_sync_en_q <= 1'b0;
      end else if (wr_take && PADDR_I == `SGM_OFS_CTRL1) begin
         high_carrier_invert_q <= PWDATA_I[`SGM_CTRL1_CHINV];
         high_carrier_sync_en_q <= PWDATA_I[`SGM_CTRL1_HIGH_CARRIER_SYNC_EN];
         low_carrier_invert_q <= PWDATA_I[`SGM_CTRL1_CLINV];
         low_carrier_sync_en_q <= PWDATA_I[`SGM_CTRL1_LOW_CARRIER_SYNC_EN];
      end
   end

   // selections only change on their own writes
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         mod_source_sel_q <= `SGM_RST_MS;
         high_carrier_sel_q <= `SGM_RST_CAR;
         low_carrier_sel_q <= `SGM_RST_CAR;
      end else begin
         if (wr_take && PADDR_I == `SGM_OFS_MODSRC) begin
            mod_source_sel_q <= PWDATA_I[`SGM_MS_W-1:0];
         end
         if (wr_take && PADDR_I == `SGM_OFS_CARRIER_HIGH) begin
            high_carrier_sel_q <= PWDATA_I[`SGM_CAR_W-1:0];
         end
         if (wr_take && PADDR_I == `SGM_OFS_CARRIER_LOW) begin
            low_carrier_sel_q <= PWDATA_I[`SGM_CAR_W-1:0];
         end
      end
   end

   // --------------------------------------------------------------- sources
   // clean levels before the sync logic
   sgm_sync #(
      .W(`SGM_MOD_SRCS)
   ) u_sync_mod (
      .clk_i(CLOCK_I),
      .srst_i(SRST_I),
      .d_i(MOD_SRC_I),
      .q_o(mod_sync)
   );

   sgm_sync #(
      .W(`SGM_CAR_SRCS)
   ) u_sync_carrier_high (
      .clk_i(CLOCK_I),
      .srst_i(SRST_I),
      .d_i(CARRIER_HIGH_SRC_I),
      .q_o(carrier_high_sync)
   );

   sgm_sync #(
      .W(`SGM_CAR_SRCS)
   ) u_sync_carrier_low (
      .clk_i(CLOCK_I),
      .srst_i(SRST_I),
      .d_i(CARRIER_LOW_SRC_I),
      .q_o(carrier_low_sync)
   );

   // internal or pin sources by index
   sgm_pick #(
      .N(`SGM_MOD_SRCS),
      .SW(`SGM_MS_W)
   ) u_pick_mod (
      .src_i(mod_sync),
      .sel_i(mod_source_sel_q),
      .pick_o(mod_pick)
   );

   sgm_pick #(
      .N(`SGM_CAR_SRCS),
      .SW(`SGM_CAR_W)
   ) u_pick_carrier_high (
      .src_i(carrier_high_sync),
      .sel_i(high_carrier_sel_q),
      .pick_o(carrier_high_pick)
   );

   sgm_pick #(
      .N(`SGM_CAR_SRCS),
      .SW(`SGM_CAR_W)
   ) u_pick_carrier_low (
      .src_i(carrier_low_sync),
      .sel_i(low_carrier_sel_q),
      .pick_o(carrier_low_pick)
   );

   // modulator level: soft bit when disabled or selected
   always_comb begin
      if (!en_q || mod_source_sel_q == `SGM_MS_SOFT_BIT) begin
         modulator_signal = soft_bit_q;
      end else begin
         modulator_signal = mod_pick;
      end
   end

   // carriers grounded when disabled, else inverted as asked
   always_comb begin
      carrier_high = en_q && (carrier_high_pick ^ high_carrier_invert_q);
      carrier_low = en_q && (carrier_low_pick ^ low_carrier_invert_q);
   end

   // ------------------------------------------------------- carrier switching
   // with its sync enable set, hold the old carrier until its pulse is low
   always_comb begin
      car_d = car_q;
      case (car_q)
         sgm_pkg::SGM_CAR_LOW: begin
            if (modulator_signal && !(low_carrier_sync_en_q && carrier_low)) begin
               car_d = sgm_pkg::SGM_CAR_HIGH;
            end
         end
         sgm_pkg::SGM_CAR_HIGH: begin
            if (!modulator_signal && !(high_carrier_sync_en_q && carrier_high)) begin
               car_d = sgm_pkg::SGM_CAR_LOW;
            end
         end
         default: begin
            car_d = sgm_pkg::SGM_CAR_LOW;
         end
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         car_q <= sgm_pkg::SGM_CAR_LOW;
      end else begin
         car_q <= car_d;
      end
   end

   // active carrier gated by the next switch state (car_d, not car_q)
   always_comb begin
      if (car_d == sgm_pkg::SGM_CAR_HIGH) begin
         mix = carrier_high;
      end else begin
         mix = carrier_low;
      end
   end

   // mixing runs regardless of pin routing
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         out_q <= 1'b0;
         MODULATED_OUTPUT_PIN_O <= 1'b0;
      end else begin
         out_q <= mix ^ out_inv_q;
         MODULATED_OUTPUT_PIN_O <= mix ^ out_inv_q;
      end
   end

   // -------------------------------------------------------------- checks
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (SRST_I);

   a_reset_defaults: assert property (
      disable iff (1'b0) SRST_I |=> !en_q && !out_q && mod_source_sel_q == `SGM_RST_MS
   ) else $error("reset did not restore defaults");

   a_enable_write: assert property (
      wr_take && PADDR_I == `SGM_OFS_CTRL0 |=> en_q == $past(PWDATA_I[`SGM_CTRL0_EN])
   ) else $error("enable bit not taken from write");

   a_disabled_idle: assert property (
      !en_q |=> MODULATED_OUTPUT_PIN_O == $past(out_inv_q)
   ) else $error("disabled output not at idle level");

   a_disabled_softbit: assert property (
      !en_q |-> modulator_signal == soft_bit_q
   ) else $error("disabled modulator not soft bit");

   a_sel_retained: assert property (
      $fell(en_q) && !$past(SRST_I) |-> $stable(mod_source_sel_q) && $stable(high_carrier_sel_q)
                      && $stable(low_carrier_sel_q)
   ) else $error("selection changed on disable");

   a_high_sync_hold: assert property (
      en_q && high_carrier_sync_en_q && car_q == sgm_pkg::SGM_CAR_HIGH && carrier_high
      |=> car_q == sgm_pkg::SGM_CAR_HIGH
   ) else $error("left high carrier mid pulse");

   a_low_sync_hold: assert property (
      en_q && low_carrier_sync_en_q && car_q == sgm_pkg::SGM_CAR_LOW && carrier_low
      |=> car_q == sgm_pkg::SGM_CAR_LOW
   ) else $error("left low carrier mid pulse");

   a_nosync_mix: assert property (
      en_q && !high_carrier_sync_en_q && !low_carrier_sync_en_q
      |=> MODULATED_OUTPUT_PIN_O == $past((modulator_signal ? carrier_high : carrier_low)
                                          ^ out_inv_q)
   ) else $error("output does not follow selected carrier");

   a_softbit_high: assert property (
      en_q && mod_source_sel_q == `SGM_MS_SOFT_BIT && soft_bit_q && !low_carrier_sync_en_q
      |=> car_q == sgm_pkg::SGM_CAR_HIGH
   ) else $error("soft bit one did not pick high carrier");

   a_apb_ready: assert property (
      access && !PREADY_O |=> PREADY_O ##1 !PREADY_O
   ) else $error("apb ready not one wait state");

   a_status_out: assert property (
      access && !PREADY_O && !PWRITE_I && PADDR_I == `SGM_OFS_CTRL0
      |=> PRDATA_O[`SGM_CTRL0_OUT] == $past(MODULATED_OUTPUT_PIN_O)
   ) else $error("status bit differs from output");

endmodule : sgm_modulator

`default_nettype wire

// ==== sgm_source_model.sv ====
// source banks feeding the modulator, with noise on lines not selected
`timescale 1ns/1ns
`default_nettype none

module sgm_source_model (
   input wire logic clk_i,
   input wire logic [31:0] mod_i,
   input wire logic [15:0] ch_i,
   input wire logic [15:0] cl_i,
   input wire logic [31:0] mod_nz_i,
   input wire logic [15:0] ch_nz_i,
   input wire logic [15:0] cl_nz_i,
   output logic [31:0] mod_o,
   output logic [15:0] ch_o,
   output logic [15:0] cl_o
);
   initial begin
      mod_o = 32'h0;
      ch_o = 16'h0;
      cl_o = 16'h0;
   end
   // noisy lines change every cycle so a wrong pick shows
   always @(posedge clk_i) begin
      mod_o <= (mod_i & ~mod_nz_i) | (32'($urandom) & mod_nz_i);
      ch_o <= (ch_i & ~ch_nz_i) | (16'($urandom) & ch_nz_i);
      cl_o <= (cl_i & ~cl_nz_i) | (16'($urandom) & cl_nz_i);
   end
endmodule : sgm_source_model

`default_nettype wire

// ==== sgm_modulator_test.sv ====
// self-checking bench for the signal modulator
`timescale 1ns/1ns
`default_nettype none

module sgm_modulator_test;
   logic clk = 1'h0;
   logic srst = 1'h1;
   logic psel = 1'h0;
   logic pen = 1'h0;
   logic pwr = 1'h0;
   logic [7:0] pad = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd;
   logic prdy;
   logic perr;
   logic pin;
   logic [31:0] mb;
   logic [15:0] hb;
   logic [15:0] lb;
   logic [31:0] mw = 32'h0;
   logic [31:0] mn = 32'h0;
   logic [15:0] hw = 16'h0;
   logic [15:0] lw = 16'h0;
   logic [15:0] hn = 16'h0;
   logic [15:0] ln = 16'h0;
   logic [31:0] rd;
   logic er;
   logic en = 1'h0;
   logic bi = 1'h0;
   logic oi = 1'h0;
   logic hi = 1'h0;
   logic li = 1'h0;
   logic [4:0] ms = 5'h00;
   logic [3:0] hs = 4'h0;
   logic [3:0] ls = 4'h0;
   logic [31:0] regs [5] = '{default: 32'h0};
   logic [31:0] mask [5] = '{32'h91, 32'h33, 32'h1F, 32'hF, 32'hF};
   int err_count = 0;
   int checks = 0;
   int cyc = 0;

   always #20 clk = ~clk;

   sgm_modulator dut (.CLOCK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(pad), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy),
      .PSLVERR_O(perr), .MOD_SRC_I(mb), .CARRIER_HIGH_SRC_I(hb), .CARRIER_LOW_SRC_I(lb),
      .MODULATED_OUTPUT_PIN_O(pin));

   sgm_source_model src (.clk_i(clk), .mod_i(mw), .ch_i(hw), .cl_i(lw), .mod_nz_i(mn),
      .ch_nz_i(hn), .cl_nz_i(ln), .mod_o(mb), .ch_o(hb), .cl_o(lb));

   task wrap_up;
      if (err_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   always @(posedge clk) begin
      cyc++;
      if (cyc > 30000) begin
         err_count++;
         wrap_up();
      end
   end

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      pad <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'h1;
      // this wait ends when ready is seen, or at the bench timeout
      do begin
         @(posedge clk);
      end while (prdy !== 1'h1);
      rd = prd;
      er = perr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask : apb

   function automatic logic exp_out();
      logic m;
      m = (!en || ms == 5'h00) ? bi : mw[ms];
      return (m ? en & (hw[hs] ^ hi) : en & (lw[ls] ^ li)) ^ oi;
   endfunction : exp_out

   task decode;
      {en, oi, bi} = {regs[0][7], regs[0][4], regs[0][0]};
      {hi, li} = {regs[1][5], regs[1][1]};
      ms = regs[2][4:0];
      hs = regs[3][3:0];
      ls = regs[4][3:0];
      mn <= ~(32'h1 << ms);
      hn <= ~(16'h1 << hs);
      ln <= ~(16'h1 << ls);
   endtask : decode

   task wr_reg(input int i, input logic [31:0] v);
      apb(1'h1, 8'(4 * i), v);
      regs[i] = v & mask[i];
      decode();
   endtask : wr_reg

   task settle_pin(input logic exp);
      repeat (8) @(posedge clk);
      chk(32'(pin), 32'(exp));
   endtask : settle_pin

   task check_regs;
      for (int i = 0; i < 5; i++) begin
         apb(1'h0, 8'(4 * i), 32'h0);
         chk(rd, i == 0 ? regs[0] | 32'(exp_out()) << 5 : regs[i]);
         chk(32'(er), 32'h0);
      end
   endtask : check_regs

   task sync_try(input logic side, input logic [31:0] c1, input logic hold);
      mw <= 32'h0;
      hw <= {14'h0, side, 1'h0};
      lw <= {13'h0, !side, 2'h0};
      wr_reg(1, c1);
      wr_reg(2, 32'h0);
      wr_reg(3, 32'h1);
      wr_reg(4, 32'h2);
      wr_reg(0, 32'h80 | 32'(side));
      settle_pin(1'h1);
      wr_reg(0, 32'h80 | 32'(!side));
      settle_pin(hold);
      hw <= 16'h0;
      lw <= 16'h0;
      settle_pin(1'h0);
      hw <= {14'h0, side, 1'h0};
      lw <= {13'h0, !side, 2'h0};
      settle_pin(1'h0);
   endtask : sync_try

   initial begin
      logic [31:0] r [5];
      void'($urandom(32'h16BEAC1F));
      repeat (8) @(posedge clk);
      srst <= 1'h0;
      check_regs();
      apb(1'h0, 8'h14, 32'h0);
      chk(rd, 32'h0);
      chk(32'(er), 32'h1);
      for (int k = 0; k < 40; k++) begin
         for (int i = 0; i < 5; i++) begin
            r[i] = $urandom;
         end
         r[0][7] = (k % 4 != 0);
         r[1] = r[1] & 32'hFFFFFFEE;
         mw <= $urandom;
         hw <= 16'($urandom);
         lw <= 16'($urandom);
         for (int i = 0; i < 5; i++) begin
            wr_reg(i, r[i]);
         end
         settle_pin(exp_out());
         check_regs();
      end
      wr_reg(0, regs[0] & 32'h7F);
      settle_pin(oi);
      check_regs();
      wr_reg(0, regs[0] | 32'h80);
      settle_pin(exp_out());
      sync_try(1'h1, 32'h10, 1'h1);
      sync_try(1'h1, 32'h01, 1'h0);
      sync_try(1'h0, 32'h01, 1'h1);
      sync_try(1'h0, 32'h10, 1'h0);
      sync_try(1'h1, 32'h00, 1'h0);
      srst <= 1'h1;
      repeat (2) @(posedge clk);
      srst <= 1'h0;
      regs = '{default: 32'h0};
      decode();
      check_regs();
      settle_pin(1'h0);
      wrap_up();
   end
endmodule : sgm_modulator_test

`default_nettype wire
